// ==== logic/civc_pkg.sv ====
// shared constants and types for the cpu interrupt vector control block
// assumes one 250 MHz system clock and an axi4-lite master on the register side
package civc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam int unsigned IDX_W = 3;
    localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0;   // interrupt_control
    localparam logic [IDX_W-1:0] IDX_STATUS = 3'h1; // interrupt_level_state
    localparam logic [IDX_W-1:0] IDX_ORDER = 3'h2;  // normal_priority_order
    localparam logic [IDX_W-1:0] IDX_HVEC = 3'h3;   // high_priority_vector
    localparam logic [IDX_W-1:0] IDX_KEY = 3'h4;    // change_protection_key, write only
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned CTRL_RR_BIT = 0;
    localparam int unsigned CTRL_CVT_BIT = 5;
    localparam int unsigned CTRL_VECTOR_PLACEMENT_SELECT_BIT = 6;
    localparam int unsigned STAT_NORM_BIT = 0;
    localparam int unsigned STAT_HIGH_BIT = 1;
    localparam int unsigned STAT_NMI_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] HVEC_NONE = 8'h00;       // no vector at high level
    localparam logic [7:0] COMPACT_NMI_ADDR = 8'h01;
    localparam logic [7:0] COMPACT_HIGH_ADDR = 8'h02;
    localparam logic [7:0] COMPACT_NORM_ADDR = 8'h03;
    localparam logic [2:0] UNLOCK_INSTRS = 3'h4;    // instructions the key stays valid
    localparam logic [2:0] UNLOCK_NONE = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // level of a presented or executing request
    typedef enum logic [1:0] {
        LVL_NORM,
        LVL_HIGH,
        LVL_NMI
    } civc_level_t;

    // request offered to the core
    typedef struct packed {
        logic valid;
        civc_level_t level;
        logic [7:0] vector;   // vector number
        logic [7:0] address;  // table slot, compacted when enabled
    } civc_irq_t;

    // whole state of the core module
    typedef struct packed {
        logic aw_rdy;
        logic aw_have;
        logic aw_ok;
        logic [IDX_W-1:0] aw_idx;
        logic w_rdy;
        logic w_have;
        logic w_en;
        logic [7:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic rr_en;
        logic cvt_en;
        logic vector_placement_select;
        logic [7:0] order;
        logic [7:0] hvec;
        logic nmi_ex;
        logic high_ex;
        logic norm_ex;
        logic [2:0] unlock_cnt;
        civc_irq_t irq;
    } civc_state_t;

endpackage

// ==== logic/civc_pick.sv ====
// rotating first-set picker over a request vector
// assumes a combinational use inside the core; no state of its own
`timescale 1ns/1ps

module civc_pick #(
    parameter int unsigned N = 32,
    parameter int unsigned IW = 5
) (
    input wire logic [N-1:0] req_i,   // candidate requests
    input wire logic [7:0] last_i,    // index that ranks lowest
    output logic hit_o,               // some request found
    output logic [IW-1:0] idx_o       // winning index
);

    ////////////////////////////////////////////////////////////////////////////
    // search starts just after last_i and wraps round
    always_comb begin
        int start;
        int j;
        start = (int'(last_i) + 1) % N;
        j = 0;
        hit_o = 1'b0;
        idx_o = '0;
        for (int i = 0; i < N; i++) begin
            j = (start + i) % N;
            // first request in rotated order wins
            if (!hit_o && req_i[j]) begin
                hit_o = 1'b1;
                idx_o = IW'(j);
            end
        end
    end

endmodule

// ==== logic/civc_core.sv ====
// cpu interrupt vector control: registers, unlock key, level tracking, selection
// assumes an axi4-lite master and a core on sys_clk_i that acks, returns and retires
`timescale 1ns/1ps

module civc_core #(
    parameter int unsigned NUM_VEC = 32,              // vectors including reset and nonmaskable
    parameter int unsigned ADDR_W = 8,                // axi address width
    parameter logic [7:0] UNLOCK_KEY = 8'h5a,         // arbitrary value
    parameter logic [NUM_VEC-1:0] NMI_MASK = 32'h2    // vectors that are nonmaskable
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [NUM_VEC-1:0] irq_req_i,  // pending request per vector number
    input wire logic global_enable_i,          // core global enable flag
    input wire logic irq_ack_i,                // core enters the presented handler
    input wire logic irq_return_i,             // core executes an interrupt return
    input wire logic instr_retire_i,           // core finished one instruction
    output civc_pkg::civc_irq_t irq_o,         // request offered to the core
    output logic vector_placement_o,           // 1: boot section, 0: application
    output logic [2:0] level_state_o           // nmi, high, normal executing
);

    localparam int unsigned IW = $clog2(NUM_VEC);

    ////////////////////////////////////////////////////////////////////////////
    // state and helper nets
    civc_pkg::civc_state_t st_r;     // registered state
    civc_pkg::civc_state_t st_nxt;   // next state
    logic nmi_hit;                   // some nonmaskable request pending
    logic [IW-1:0] nmi_idx;          // lowest pending nonmaskable vector
    logic norm_hit;                  // some normal request pending
    logic [IW-1:0] norm_idx;         // winning normal vector
    logic high_hit;                  // selected high vector pending
    logic hvec_in_range;             // high vector names a real vector
    logic [NUM_VEC-1:0] high_bit;    // one-hot of the high vector
    logic [NUM_VEC-1:0] norm_req;    // requests left at normal level

    // whether an address is word aligned and maps to a register index
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a[1:0] == civc_pkg::WORD_ALIGN)
               && ((a >> (civc_pkg::IDX_W + 2)) == '0)
               && (a[civc_pkg::IDX_W+1:2] <= civc_pkg::IDX_KEY);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // request classification
    always_comb begin
        hvec_in_range = (int'(st_r.hvec) < NUM_VEC);
        high_bit = '0;
        if (st_r.hvec != civc_pkg::HVEC_NONE && hvec_in_range) begin
            high_bit[st_r.hvec[IW-1:0]] = 1'b1;
        end
        high_hit = |(irq_req_i & high_bit & ~NMI_MASK);
        // vector zero is reset and never arbitrated here
        norm_req = irq_req_i & ~NMI_MASK & ~high_bit & ~NUM_VEC'(1);
    end

    // nonmaskable: static, lowest vector first
    civc_pick #(
        .N(NUM_VEC),
        .IW(IW)
    ) u_nmi_pick (
        .req_i(irq_req_i & NMI_MASK),
        .last_i(8'(NUM_VEC - 1)),
        .hit_o(nmi_hit),
        .idx_o(nmi_idx)
    );

    civc_pick #(
        .N(NUM_VEC),
        .IW(IW)
    ) u_norm_pick (
        .req_i(norm_req),
        .last_i(st_r.order),
        .hit_o(norm_hit),
        .idx_o(norm_idx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [IW-1:0] sel_idx;
        civc_pkg::civc_level_t sel_lvl;
        logic sel_hit;
        logic [7:0] rd;
        logic [civc_pkg::IDX_W-1:0] ridx;
        sel_idx = '0;
        sel_lvl = civc_pkg::LVL_NORM;
        sel_hit = 1'b0;
        rd = civc_pkg::REG_RESET;
        ridx = s_axi_araddr_i[civc_pkg::IDX_W+1:2];
        st_nxt = st_r;

        // write address channel, latched until the write is done
        if (st_r.aw_rdy && s_axi_awvalid_i) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_ok = addr_ok(s_axi_awaddr_i);
            st_nxt.aw_idx = s_axi_awaddr_i[civc_pkg::IDX_W+1:2];
        end
        // write data channel; only the low byte lane carries a register
        if (st_r.w_rdy && s_axi_wvalid_i) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_en = s_axi_wstrb_i[0];
            st_nxt.w_data = s_axi_wdata_i[7:0];
        end
        // response handshake
        if (st_r.bvalid && s_axi_bready_i) begin
            st_nxt.bvalid = 1'b0;
        end

        if (instr_retire_i && st_r.unlock_cnt != civc_pkg::UNLOCK_NONE) begin
            st_nxt.unlock_cnt = st_r.unlock_cnt - 3'h1;
        end

        // register write once both halves are in and the response slot is free
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = st_r.aw_ok ? civc_pkg::RESP_OKAY : civc_pkg::RESP_SLVERR;
            if (st_r.aw_ok && st_r.w_en) begin
                unique case (st_r.aw_idx)
                    civc_pkg::IDX_CTRL: begin
                        st_nxt.rr_en = st_r.w_data[civc_pkg::CTRL_RR_BIT];
                        if (st_r.unlock_cnt != civc_pkg::UNLOCK_NONE) begin
                            st_nxt.cvt_en = st_r.w_data[civc_pkg::CTRL_CVT_BIT];
                            st_nxt.vector_placement_select = st_r.w_data[civc_pkg::CTRL_VECTOR_PLACEMENT_SELECT_BIT];
                        end
                        // any control write spends the key
                        st_nxt.unlock_cnt = civc_pkg::UNLOCK_NONE;
                    end
                    civc_pkg::IDX_ORDER: begin
                        st_nxt.order = st_r.w_data;
                    end
                    civc_pkg::IDX_HVEC: begin
                        st_nxt.hvec = st_r.w_data;
                    end
                    civc_pkg::IDX_KEY: begin
                        if (st_r.w_data == UNLOCK_KEY) begin
                            st_nxt.unlock_cnt = civc_pkg::UNLOCK_INSTRS;
                        end
                    end
                    default: begin
                        // status is read only; the write is answered and dropped
                    end
                endcase
            end
        end

        // read channel: one read in flight, answered one cycle after it is taken
        if (st_r.rvalid && s_axi_rready_i) begin
            st_nxt.rvalid = 1'b0;
        end
        if (st_r.ar_rdy && s_axi_arvalid_i) begin
            unique case (ridx)
                civc_pkg::IDX_CTRL: begin
                    rd[civc_pkg::CTRL_RR_BIT] = st_r.rr_en;
                    rd[civc_pkg::CTRL_CVT_BIT] = st_r.cvt_en;
                    rd[civc_pkg::CTRL_VECTOR_PLACEMENT_SELECT_BIT] = st_r.vector_placement_select;
                end
                civc_pkg::IDX_STATUS: begin
                    rd[civc_pkg::STAT_NORM_BIT] = st_r.norm_ex;
                    rd[civc_pkg::STAT_HIGH_BIT] = st_r.high_ex;
                    rd[civc_pkg::STAT_NMI_BIT] = st_r.nmi_ex;
                end
                civc_pkg::IDX_ORDER: rd = st_r.order;
                civc_pkg::IDX_HVEC: rd = st_r.hvec;
                default: rd = civc_pkg::REG_RESET;  // key and holes read zero
            endcase
            st_nxt.rvalid = 1'b1;
            // unmapped addresses read zero, in step with the slverr answer
            st_nxt.rdata = addr_ok(s_axi_araddr_i) ? rd : civc_pkg::REG_RESET;
            st_nxt.rresp = addr_ok(s_axi_araddr_i) ? civc_pkg::RESP_OKAY : civc_pkg::RESP_SLVERR;
        end

        // return clears the innermost level only
        if (irq_return_i) begin
            if (st_r.nmi_ex) begin
                st_nxt.nmi_ex = 1'b0;
            end else if (st_r.high_ex) begin
                st_nxt.high_ex = 1'b0;
            end else begin
                st_nxt.norm_ex = 1'b0;
            end
        end

        // entry into the presented handler
        if (irq_ack_i && st_r.irq.valid) begin
            unique case (st_r.irq.level)
                civc_pkg::LVL_NMI: st_nxt.nmi_ex = 1'b1;
                civc_pkg::LVL_HIGH: st_nxt.high_ex = 1'b1;
                civc_pkg::LVL_NORM: begin
                    st_nxt.norm_ex = 1'b1;
                    if (st_r.rr_en) begin
                        st_nxt.order = st_r.irq.vector;
                    end
                end
            endcase
        end

        if (nmi_hit && !st_r.nmi_ex) begin
            sel_hit = 1'b1;
            sel_lvl = civc_pkg::LVL_NMI;
            sel_idx = nmi_idx;
        end else if (high_hit && global_enable_i && !st_r.nmi_ex && !st_r.high_ex) begin
            sel_hit = 1'b1;
            sel_lvl = civc_pkg::LVL_HIGH;
            sel_idx = st_r.hvec[IW-1:0];
        end else if (norm_hit && global_enable_i && !st_r.nmi_ex && !st_r.high_ex && !st_r.norm_ex) begin
            // fixed or rotating via order register
            sel_hit = 1'b1;
            sel_lvl = civc_pkg::LVL_NORM;
            sel_idx = norm_idx;
        end

        // offer is withdrawn in the acknowledge cycle so status settles first
        st_nxt.irq.valid = sel_hit && !(irq_ack_i && st_r.irq.valid);
        st_nxt.irq.level = sel_lvl;
        st_nxt.irq.vector = 8'(sel_idx);
        if (st_r.cvt_en) begin
            unique case (sel_lvl)
                civc_pkg::LVL_NMI: st_nxt.irq.address = civc_pkg::COMPACT_NMI_ADDR;
                civc_pkg::LVL_HIGH: st_nxt.irq.address = civc_pkg::COMPACT_HIGH_ADDR;
                civc_pkg::LVL_NORM: st_nxt.irq.address = civc_pkg::COMPACT_NORM_ADDR;
            endcase
        end else begin
            st_nxt.irq.address = 8'(sel_idx);
        end

        // ready flags follow the held items so they come straight from flops
        st_nxt.aw_rdy = !st_nxt.aw_have;
        st_nxt.w_rdy = !st_nxt.w_have;
        st_nxt.ar_rdy = !st_nxt.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; synchronous reset
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.order <= civc_pkg::REG_RESET;
            st_r.hvec <= civc_pkg::HVEC_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; readies are low for the first cycle after reset, then high
    assign s_axi_awready_o = st_r.aw_rdy;
    assign s_axi_wready_o = st_r.w_rdy;
    assign s_axi_bvalid_o = st_r.bvalid;
    assign s_axi_bresp_o = st_r.bresp;
    assign s_axi_arready_o = st_r.ar_rdy;
    assign s_axi_rvalid_o = st_r.rvalid;
    assign s_axi_rresp_o = st_r.rresp;
    assign s_axi_rdata_o = {24'h000000, st_r.rdata};
    assign irq_o = st_r.irq;
    assign vector_placement_o = st_r.vector_placement_select;
    assign level_state_o = {st_r.nmi_ex, st_r.high_ex, st_r.norm_ex};

endmodule

// ==== verification/civc_monitor.sv ====
// concurrent checks on the interrupt vector control ports
// assumes a single clock domain and the synchronous active-low reset
`timescale 1ns/1ps

module civc_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic global_enable_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    input wire civc_pkg::civc_irq_t irq_o,
    input wire logic [2:0] level_state_o
);
    // an entry that counts: offered, acked, no return on the same edge
    logic take;
    assign take = irq_ack_i && irq_o.valid && !irq_return_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    chk_norm_set: assert property (
        take && irq_o.level == civc_pkg::LVL_NORM |=> level_state_o[0]) else $error("normal flag not set");
    chk_high_set: assert property (
        take && irq_o.level == civc_pkg::LVL_HIGH |=> level_state_o[1]) else $error("high flag not set");
    chk_nmi_set: assert property (
        take && irq_o.level == civc_pkg::LVL_NMI |=> level_state_o[2]) else $error("nmi flag not set");
    chk_nmi_block: assert property (level_state_o[2] |-> !irq_o.valid)
        else $error("offer while nmi handler runs");
    chk_gate_enable: assert property (
        irq_o.valid && irq_o.level != civc_pkg::LVL_NMI |-> $past(global_enable_i)) else $error("offer while disabled");
    chk_nmi_return: assert property (
        irq_return_i && !irq_ack_i && level_state_o[2] |=> level_state_o == {1'b0, $past(level_state_o[1:0])})
        else $error("nmi return restored wrong level");
    chk_high_return: assert property (
        irq_return_i && !irq_ack_i && level_state_o == 3'h3 |=> level_state_o == 3'h1)
        else $error("high return restored wrong level");
    // compacted slots only take the three fixed addresses
    chk_compact_addr: assert property (irq_o.valid && irq_o.address != irq_o.vector |-> irq_o.address ==
        (irq_o.level == civc_pkg::LVL_NMI ? 8'h01 : irq_o.level == civc_pkg::LVL_HIGH ? 8'h02 : 8'h03))
        else $error("compact address wrong");
    cover property (take && irq_o.level == civc_pkg::LVL_NMI);
    cover property (irq_return_i && level_state_o == 3'h7);
    cover property (irq_o.valid && irq_o.address != irq_o.vector);
endmodule

bind civc_core civc_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .global_enable_i(global_enable_i), .irq_ack_i(irq_ack_i), .irq_return_i(irq_return_i),
    .irq_o(irq_o), .level_state_o(level_state_o));

// ==== verification/civc_core_model.sv ====
// processor core model: enters offered handlers, returns, retires instructions
// assumes the bench steers it through take_i, ret_i and run_i
`timescale 1ns/1ps

module civc_core_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire civc_pkg::civc_irq_t irq_i,
    input wire logic take_i,
    input wire logic ret_i,
    input wire logic run_i,
    output logic irq_ack_o,
    output logic irq_return_o,
    output logic instr_retire_o
);
    ////////////////////////////////////////////////////////////
    // one pulse per request; an entry only while a handler is offered
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_ack_o <= 1'b0;
            irq_return_o <= 1'b0;
            instr_retire_o <= 1'b0;
        end else begin
            irq_ack_o <= take_i && irq_i.valid && !irq_ack_o;
            irq_return_o <= ret_i && !irq_return_o;
            instr_retire_o <= run_i;
        end
    end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the interrupt vector control block
// assumes the core model drives acks, returns and retired instructions
`timescale 1ns/1ps

module tb_top;
    localparam logic [7:0] KEY = 8'h5a; // arbitrary unlock value
    localparam logic [1:0] OK = civc_pkg::RESP_OKAY;
    localparam logic [1:0] SE = civc_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] req = 32'h0;
    logic [3:0] strb = 4'h1; // write lane strobes
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic gen = 1'b0, take = 1'b0, ret = 1'b0, run = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ack, rtn, rtr, vpo;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] ls;
    civc_pkg::civc_irq_t irq;
    int error_cnt = 0;
    int n_compared = 0;

    always #2 clk = ~clk;

    civc_core #(.UNLOCK_KEY(KEY)) dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .irq_req_i(req), .global_enable_i(gen), .irq_ack_i(ack), .irq_return_i(rtn),
        .instr_retire_i(rtr), .irq_o(irq), .vector_placement_o(vpo), .level_state_o(ls));
    civc_core_model core (.sys_clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .take_i(take), .ret_i(ret),
        .run_i(run), .irq_ack_o(ack), .irq_return_o(rtn), .instr_retire_o(rtr));

    ////////////////////////////////////////////////////////////
    task automatic close_out;
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // expected offer: valid, level, vector, slot address
    function automatic logic [39:0] ex(input logic [1:0] l, input logic [7:0] v, input logic [7:0] a);
        return {21'h0, 1'b1, l, v, a};
    endfunction
    // axi4-lite write; both channels offered at once, each dropped when taken
    // bready rises only once bvalid is seen, so the held response is exercised
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (awready === 1'b1) pa = 1'b0;
            if (wready === 1'b1) pw = 1'b0;
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    // axi4-lite read, response code and data checked together
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        // rready late by one cycle so the read data must stand
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk({rresp, rdata}, {er, 24'h0, e});
    endtask
    // key, then n retired instructions before the caller's write
    task automatic unlock(input int n);
        wr(8'h10, KEY, OK);
        if (n > 0) begin
            run <= 1'b1;
            cyc(n);
            run <= 1'b0;
        end
    endtask
    task automatic enter;
        take <= 1'b1;
        cyc(1);
        take <= 1'b0;
        cyc(3);
    endtask
    task automatic leave;
        ret <= 1'b1;
        cyc(1);
        ret <= 1'b0;
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #40000;
        error_cnt++;
        close_out();
    end
    initial begin
        cyc(2);
        rst_n <= 1'b1;
        cyc(2);
        rc(8'h00, 8'h00, OK);
        rc(8'h04, 8'h00, OK);
        rc(8'h08, 8'h00, OK);
        rc(8'h0c, 8'h00, OK);
        rc(8'h10, 8'h00, OK);
        rc(8'h14, 8'h00, SE);
        rc(8'h05, 8'h00, SE);
        // refused, read-only and strobe-masked writes leave registers alone
        wr(8'h14, 8'h55, SE);
        wr(8'h04, 8'h83, OK);
        rc(8'h04, 8'h00, OK);
        strb <= 4'h0;
        wr(8'h08, 8'h55, OK);
        strb <= 4'h1;
        rc(8'h08, 8'h00, OK);
        // protected bits dropped, rotating bit kept
        wr(8'h00, 8'h61, OK);
        rc(8'h00, 8'h01, OK);
        chk(vpo, 1'b0);
        unlock(0);
        wr(8'h00, 8'h61, OK);
        rc(8'h00, 8'h61, OK);
        chk(vpo, 1'b1);
        // key expires after four instructions, not after three
        unlock(4);
        wr(8'h00, 8'h00, OK);
        rc(8'h00, 8'h60, OK);
        unlock(3);
        wr(8'h00, 8'h20, OK);
        rc(8'h00, 8'h20, OK);
        chk(vpo, 1'b0);
        // compact table with nested entries
        gen <= 1'b1;
        req <= 32'h20;
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NORM, 8'h05, 8'h03));
        enter();
        chk(ls, 3'h1);
        wr(8'h0c, 8'h07, OK);
        req <= 32'ha0;
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_HIGH, 8'h07, 8'h02));
        enter();
        chk(ls, 3'h3);
        req <= 32'ha2;
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NMI, 8'h01, 8'h01));
        enter();
        chk(ls, 3'h7);
        req <= 32'h0;
        leave();
        chk(ls, 3'h3);
        leave();
        chk(ls, 3'h1);
        leave();
        chk(ls, 3'h0);
        // fixed ordering, full table, high level off
        unlock(0);
        wr(8'h00, 8'h00, OK);
        wr(8'h0c, 8'h00, OK);
        req <= 32'h68;
        wr(8'h08, 8'h05, OK);
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NORM, 8'h06, 8'h06));
        wr(8'h08, 8'h00, OK);
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NORM, 8'h03, 8'h03));
        req <= 32'h80;
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NORM, 8'h07, 8'h07));
        // rotating order follows each normal-level entry
        wr(8'h00, 8'h01, OK);
        req <= 32'h68;
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NORM, 8'h03, 8'h03));
        enter();
        rc(8'h08, 8'h03, OK);
        leave();
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NORM, 8'h05, 8'h05));
        // global enable gates all but the nonmaskable level
        gen <= 1'b0;
        cyc(2);
        chk(irq.valid, 1'b0);
        req <= 32'h6a;
        cyc(2);
        chk(irq, ex(civc_pkg::LVL_NMI, 8'h01, 8'h01));
        close_out();
    end
endmodule
